// >>> verilog/sps_dev_end.sv
// Functional notes
// - Device only answers master-started transfers
// - Polarity, phase, frame size match master
// - Flag underflow when clocked after drain
// - Master idles select between transfers
// - Master clocks slower than device services
// - Fill flag and receive pop register
// - Master sends frames of 1 to 16 bits
// - Frame start loads entry or dummy
`timescale 1ns/1ps
`default_nettype none
module sps_dev_end
  import sps_pkg::*;
#(
  parameter int DW = MAX_BITS // Widest frame
) (
  input  wire logic              core_clk, // Module clock
  input  wire logic              resetn,   // Async reset, active low
  input  wire logic              psel,     // APB select
  input  wire logic              penable,  // APB enable
  input  wire logic              pwrite,   // APB direction
  input  wire logic [ADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [31:0]       pwdata,   // APB write data
  output logic      [31:0]       prdata,   // APB read data
  output logic                   pready,   // APB ready
  output logic                   pslverr,  // APB error
  output logic                   irq,      // Level interrupt
  sps_link_if.dev                link      // Serial link
);
  logic [2:0]        lnkS;
  logic              ssPrevQ, ssPrevD, sckPrevQ, sckPrevD;
  logic [7:0]        ctrlQ, ctrlD;
  logic [STAT_W-1:0] maskQ, maskD, statV;
  logic              tcfQ, tcfD, ufQ, ufD, rxFullQ, rxFullD;
  logic              dummyQ, dummyD;
  logic [DW-1:0]     txqQ, txqD, txShQ, txShD, rxShQ, rxShD, rxQ, rxD;
  logic [DW-1:0]     loadWord, srcWord;
  logic              txqValidQ, txqValidD;
  logic              misoQ, misoD, misoOeQ, misoOeD;
  logic [LEN_W-1:0]  bitCntQ, bitCntD, frmLen;
  logic [31:0]       prdataD;
  logic              preadyD, pslverrD, irqD;
  logic              access, xfer, mapped, rdStat;
  logic              sel, cpol, cpha, edgeSeen, lead, trail;
  logic              sampleE, shiftE, lastBit, load;

  // Pins cross into the module clock before any logic looks at them
  sps_sync #(.W(3), .INIT(3'b100)) u_sync (
    .clk    (core_clk),
    .resetn (resetn),
    .din    ({link.ssN, link.sclk, link.mosi}),
    .dout   (lnkS)
  );

  always_comb begin
    cpol   = ctrlQ[CTL_CPOL];
    cpha   = ctrlQ[CTL_CPHA];
    frmLen = ctrlQ[CTL_LEN_LSB +: LEN_W];

    // Link edge decode
    sel      = !lnkS[2];
    edgeSeen = sel && !ssPrevQ && (lnkS[1] != sckPrevQ);
    lead     = edgeSeen && (lnkS[1] != cpol);
    trail    = edgeSeen && (lnkS[1] == cpol);
    sampleE  = cpha ? trail : lead;
    shiftE   = cpha ? lead : trail;
    lastBit  = sampleE && (bitCntQ == frmLen);
    // Reload at select or back to back while select stays low
    load     = (sel && ssPrevQ) || lastBit;
    srcWord  = txqValidQ ? txqQ : {DW{DUMMY_BIT}};
    loadWord = srcWord << (LEN_W'(DW - 1) - frmLen);

    // Status view
    statV            = '0;
    statV[ST_TXFILL] = !txqValidQ;
    statV[ST_TCF]    = tcfQ;
    statV[ST_RXFULL] = rxFullQ;
    statV[ST_UF]     = ufQ;

    // APB slave: one wait state, effects at the edge that sees pready
    access   = psel && penable && !pready;
    xfer     = psel && penable && pready;
    mapped   = (paddr == OFS_CTRL) || (paddr == OFS_STAT) || (paddr == OFS_MASK) ||
               (paddr == OFS_TX) || (paddr == OFS_RX);
    preadyD  = access;
    pslverrD = access && !mapped;
    prdataD  = '0;
    if (access && !pwrite) begin
      case (paddr)
        OFS_CTRL: prdataD = {24'h0, ctrlQ};
        OFS_STAT: prdataD = {{(32 - STAT_W){1'b0}}, statV};
        OFS_MASK: prdataD = {{(32 - STAT_W){1'b0}}, maskQ};
        OFS_RX:   prdataD = {{(32 - DW){1'b0}}, rxQ};
        default:  prdataD = '0;
      endcase
    end
    rdStat = xfer && !pwrite && (paddr == OFS_STAT);

    // Hold by default; clears come first so that a set in this cycle wins
    ssPrevD   = lnkS[2];
    sckPrevD  = lnkS[1];
    ctrlD     = ctrlQ;
    maskD     = maskQ;
    tcfD      = tcfQ && !(rdStat && prdata[ST_TCF]);
    ufD       = ufQ && !(rdStat && prdata[ST_UF]);
    rxFullD   = rxFullQ && !(xfer && !pwrite && paddr == OFS_RX);
    dummyD    = dummyQ;
    txqD      = txqQ;
    txqValidD = txqValidQ;
    txShD     = txShQ;
    rxShD     = rxShQ;
    rxD       = rxQ;
    bitCntD   = bitCntQ;
    misoD     = misoQ;
    misoOeD   = sel;

    if (xfer && pwrite && paddr == OFS_CTRL) begin
      ctrlD = pwdata[7:0] & CTRL_WMASK;
    end
    if (xfer && pwrite && paddr == OFS_MASK) begin
      maskD = pwdata[STAT_W-1:0];
    end

    // Clocking only while selected; load starts a frame at select or on the last sample
    if (sampleE) begin
      rxShD   = {rxShQ[DW-2:0], lnkS[0]};
      bitCntD = bitCntQ + 1'b1;
      if (dummyQ) begin
        ufD = 1'b1;
      end
    end
    if (lastBit) begin
      rxD     = {rxShQ[DW-2:0], lnkS[0]};
      rxFullD = 1'b1;
      tcfD    = 1'b1;
    end
    if (load) begin
      txShD     = loadWord;
      rxShD     = '0;
      bitCntD   = '0;
      txqValidD = 1'b0;
      dummyD    = !txqValidQ;
      if (!cpha) begin
        misoD = loadWord[DW-1];
      end
    end else if (shiftE && (cpha || bitCntQ != '0)) begin
      // Phase 0 skips the trailing edge after the last sample
      misoD = cpha ? txShQ[DW-1] : txShQ[DW-2];
      txShD = txShQ << 1;
    end

    // A push to a full queue is dropped; software polls the fill flag
    if (xfer && pwrite && paddr == OFS_TX && !txqValidD) begin
      txqD      = pwdata[DW-1:0];
      txqValidD = 1'b1;
    end

    irqD = |(statV & maskQ);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ssPrevQ   <= 1'b1;
      sckPrevQ  <= 1'b0;
      ctrlQ     <= CTRL_RST;
      maskQ     <= MASK_RST;
      tcfQ      <= 1'b0;
      ufQ       <= 1'b0;
      rxFullQ   <= 1'b0;
      dummyQ    <= 1'b0;
      txqQ      <= '0;
      txqValidQ <= 1'b0;
      txShQ     <= '0;
      rxShQ     <= '0;
      rxQ       <= '0;
      bitCntQ   <= '0;
      misoQ     <= 1'b0;
      misoOeQ   <= 1'b0;
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irq       <= 1'b0;
    end else begin
      ssPrevQ   <= ssPrevD;
      sckPrevQ  <= sckPrevD;
      ctrlQ     <= ctrlD;
      maskQ     <= maskD;
      tcfQ      <= tcfD;
      ufQ       <= ufD;
      rxFullQ   <= rxFullD;
      dummyQ    <= dummyD;
      txqQ      <= txqD;
      txqValidQ <= txqValidD;
      txShQ     <= txShD;
      rxShQ     <= rxShD;
      rxQ       <= rxD;
      bitCntQ   <= bitCntD;
      misoQ     <= misoD;
      misoOeQ   <= misoOeD;
      prdata    <= prdataD;
      pready    <= preadyD;
      pslverr   <= pslverrD;
      irq       <= irqD;
    end
  end

  // Data line held while deselected, enable dropped
  assign link.miso   = misoQ;
  assign link.misoOe = misoOeQ;
endmodule
`default_nettype wire

// >>> verilog/sps_pkg.sv
package sps_pkg;
  // Frame and bus geometry
  localparam int MAX_BITS = 16;
  localparam int LEN_W    = 4;
  localparam int ADDR_W   = 8;
  localparam int STAT_W   = 4;

  // Register offsets, shared by both ends
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TX   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RX   = 8'h10;

  // Control fields
  localparam int         CTL_CPOL    = 0;
  localparam int         CTL_CPHA    = 1;
  localparam int         CTL_LEN_LSB = 4;
  localparam logic [7:0] CTRL_WMASK  = 8'hF3;
  localparam logic [7:0] CTRL_RST    = 8'h70;

  // Device status bits
  localparam int ST_TXFILL = 0;
  localparam int ST_TCF    = 1;
  localparam int ST_RXFULL = 2;
  localparam int ST_UF     = 3;
  // Controller status bits
  localparam int ST_BUSY   = 0;
  localparam int ST_DONE   = 1;

  localparam logic [STAT_W-1:0] MASK_RST  = 4'h0;
  localparam logic              DUMMY_BIT = 1'h1;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int GAP_NS        = 32;
  localparam int GAP_CYC_RAW   = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC       = (GAP_CYC_RAW < 1) ? 1 : GAP_CYC_RAW;
  localparam int SCK_HALF_CYC  = 8;
  localparam int TMR_W         = 8;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_SEL  = 2'h1,
    HS_CLK  = 2'h3,
    HS_GAP  = 2'h2
  } sps_hstate_e;
endpackage

// >>> verilog/sps_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sps_link_if;
  logic sclk;     // Serial clock from controller
  logic ssN;      // Select, active low
  logic mosi;     // Controller to device data
  logic miso;     // Device to controller data
  logic misoOe;   // Device drives miso
  logic misoLine; // Resolved miso wire

  // Pull-up when the device lets go of the line
  assign misoLine = misoOe ? miso : 1'b1;

  modport dev  (input sclk, input ssN, input mosi, output miso, output misoOe);
  modport host (output sclk, output ssN, output mosi, input misoLine);
endinterface
`default_nettype wire

// >>> verilog/sps_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sps_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,    // Sampling clock
  input  wire logic         resetn, // Async reset, active low
  input  wire logic [W-1:0] din,    // Asynchronous inputs
  output logic      [W-1:0] dout    // Synchronised outputs
);
  logic [W-1:0] metaQ;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      metaQ <= INIT;
      dout  <= INIT;
    end else begin
      metaQ <= din;
      dout  <= metaQ;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/sps_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module sps_host_end
  import sps_pkg::*;
#(
  parameter int DW   = MAX_BITS,    // Widest frame
  parameter int HALF = SCK_HALF_CYC // Clock half period, cycles
) (
  input  wire logic              core_clk, // Module clock
  input  wire logic              resetn,   // Async reset, active low
  input  wire logic              psel,     // APB select
  input  wire logic              penable,  // APB enable
  input  wire logic              pwrite,   // APB direction
  input  wire logic [ADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [31:0]       pwdata,   // APB write data
  output logic      [31:0]       prdata,   // APB read data
  output logic                   pready,   // APB ready
  output logic                   pslverr,  // APB error
  output logic                   irq,      // Level interrupt
  sps_link_if.host               link      // Serial link
);
  sps_hstate_e      stateQ, stateD;
  logic [TMR_W-1:0] timerQ, timerD;
  logic [7:0]       ctrlQ, ctrlD;
  logic [STAT_W-1:0] maskQ, maskD, statV;
  logic [DW-1:0]    txShQ, txShD, rxShQ, rxShD, rxQ, rxD, loadWord;
  logic [LEN_W:0]   bitCntQ, bitCntD;
  logic             sckQ, sckD, ssNQ, ssND, mosiQ, mosiD, doneQ, doneD;
  logic [31:0]      prdataD;
  logic             preadyD, pslverrD, irqD, access, xfer, mapped, misoS;
  logic             cpol, cpha, leadE, tmrDone;
  logic [LEN_W-1:0] frmLen;

  sps_sync #(.W(1), .INIT(1'b1)) u_sync (
    .clk    (core_clk),
    .resetn (resetn),
    .din    (link.misoLine),
    .dout   (misoS)
  );

  always_comb begin
    cpol     = ctrlQ[CTL_CPOL];
    cpha     = ctrlQ[CTL_CPHA];
    frmLen   = ctrlQ[CTL_LEN_LSB +: LEN_W];
    loadWord = pwdata[DW-1:0] << (LEN_W'(DW - 1) - frmLen);
    tmrDone  = (timerQ == '0);
    leadE    = (sckQ == cpol);
    statV    = '0;
    statV[ST_BUSY] = (stateQ != HS_IDLE);
    statV[ST_DONE] = doneQ;
    access   = psel && penable && !pready;
    xfer     = psel && penable && pready;
    mapped   = (paddr == OFS_CTRL) || (paddr == OFS_STAT) || (paddr == OFS_MASK) ||
               (paddr == OFS_TX) || (paddr == OFS_RX);
    preadyD  = access;
    pslverrD = access && !mapped;
    prdataD  = '0;
    if (access && !pwrite) begin
      case (paddr)
        OFS_CTRL: prdataD = {24'h0, ctrlQ};
        OFS_STAT: prdataD = {{(32 - STAT_W){1'b0}}, statV};
        OFS_MASK: prdataD = {{(32 - STAT_W){1'b0}}, maskQ};
        OFS_RX:   prdataD = {{(32 - DW){1'b0}}, rxQ};
        default:  prdataD = '0;
      endcase
    end
    stateD  = stateQ;
    timerD  = tmrDone ? timerQ : timerQ - 1'b1;
    ctrlD   = ctrlQ;
    maskD   = maskQ;
    txShD   = txShQ;
    rxShD   = rxShQ;
    rxD     = rxQ;
    bitCntD = bitCntQ;
    sckD    = sckQ;
    ssND    = ssNQ;
    mosiD   = mosiQ;
    // Clear only what the status read showed, so a new completion survives
    doneD   = doneQ && !(xfer && !pwrite && paddr == OFS_STAT && prdata[ST_DONE]);
    if (xfer && pwrite && paddr == OFS_CTRL) begin
      ctrlD = pwdata[7:0] & CTRL_WMASK;
    end
    if (xfer && pwrite && paddr == OFS_MASK) begin
      maskD = pwdata[STAT_W-1:0];
    end
    case (stateQ)
      HS_IDLE: begin
        sckD = cpol;
        ssND = 1'b1;
        if (xfer && pwrite && paddr == OFS_TX) begin
          stateD  = HS_SEL;
          ssND    = 1'b0;
          txShD   = loadWord;
          mosiD   = loadWord[DW-1];
          rxShD   = '0;
          bitCntD = '0;
          timerD  = TMR_W'(HALF - 1);
        end
      end
      HS_SEL: begin
        if (tmrDone) begin
          stateD = HS_CLK;
          timerD = TMR_W'(HALF - 1);
        end
      end
      HS_CLK: begin
        if (tmrDone) begin
          timerD = TMR_W'(HALF - 1);
          if (bitCntQ == {1'b0, frmLen} + 1'b1) begin
            stateD = HS_GAP;
            ssND   = 1'b1;
            sckD   = cpol;
            rxD    = rxShQ;
            timerD = TMR_W'(GAP_CYC - 1);
          end else begin
            sckD = !sckQ;
            if (leadE != cpha) begin
              rxShD = {rxShQ[DW-2:0], misoS};
            end
            if (leadE == cpha) begin
              mosiD = cpha ? txShQ[DW-1] : txShQ[DW-2];
              txShD = txShQ << 1;
            end
            if (!leadE) begin
              bitCntD = bitCntQ + 1'b1;
            end
          end
        end
      end
      HS_GAP: begin
        if (tmrDone) begin
          stateD = HS_IDLE;
          doneD  = 1'b1;
        end
      end
      default: stateD = HS_IDLE;
    endcase
    irqD = |(statV & maskQ);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stateQ  <= HS_IDLE;
      timerQ  <= '0;
      ctrlQ   <= CTRL_RST;
      maskQ   <= MASK_RST;
      txShQ   <= '0;
      rxShQ   <= '0;
      rxQ     <= '0;
      bitCntQ <= '0;
      sckQ    <= 1'b0;
      ssNQ    <= 1'b1;
      mosiQ   <= 1'b0;
      doneQ   <= 1'b0;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      stateQ  <= stateD;
      timerQ  <= timerD;
      ctrlQ   <= ctrlD;
      maskQ   <= maskD;
      txShQ   <= txShD;
      rxShQ   <= rxShD;
      rxQ     <= rxD;
      bitCntQ <= bitCntD;
      sckQ    <= sckD;
      ssNQ    <= ssND;
      mosiQ   <= mosiD;
      doneQ   <= doneD;
      prdata  <= prdataD;
      pready  <= preadyD;
      pslverr <= pslverrD;
      irq     <= irqD;
    end
  end

  assign link.sclk = sckQ;
  assign link.ssN  = ssNQ;
  assign link.mosi = mosiQ;
endmodule
`default_nettype wire

// >>> verif/sps_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sps_link_sva (
  input wire logic core_clk, // Module clock
  input wire logic resetn,   // Async reset, active low
  input wire logic sclk,     // Serial clock
  input wire logic ssN,      // Select, active low
  input wire logic mosi,     // Controller data
  input wire logic miso,     // Device data
  input wire logic misoOe    // Device drive enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_oe_on; $fell(ssN) |-> ##[3:4] misoOe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso enable late");
  property p_oe_off; $rose(ssN) |-> ##[3:4] !misoOe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso kept on");
  property p_oe_idle; ssN [*5] |-> !misoOe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven idle");
  property p_miso_hold; ssN [*5] |-> $stable(miso); endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved idle");
  property p_lead; $fell(ssN) |-> $stable(sclk) [*8]; endproperty
  a_lead: assert property (p_lead) else $error("sclk too early");
  property p_half; $changed(sclk) && !ssN |=> $stable(sclk) [*7]; endproperty
  a_half: assert property (p_half) else $error("sclk half short");
  property p_gap; $rose(ssN) |=> ssN; endproperty
  a_gap: assert property (p_gap) else $error("select gap short");
  property p_mosi_idle; ssN [*2] |-> $stable(mosi); endproperty
  a_mosi_idle: assert property (p_mosi_idle) else $error("mosi moved idle");

  c_frame: cover property ($fell(ssN));
  c_drive: cover property ($rose(misoOe));
  c_edge:  cover property (!ssN && $rose(sclk));
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sps_pkg::*;
;
  localparam int H = 0;
  localparam int D = 1;
  localparam int E = 2;
  localparam logic [31:0] ROW_CTL [7] = '{32'h70, 32'h71, 32'h72, 32'h73, 32'hF0, 32'h00, 32'h63};
  localparam logic [31:0] ROW_HTX [7] = '{32'hA5, 32'h96, 32'hC3, 32'h5A, 32'h8001, 32'h1, 32'hD5};
  localparam logic [31:0] ROW_DTX [7] = '{32'h3C, 32'hE1, 32'h18, 32'hA6, 32'h7FFE, 32'h2, 32'h2A};
  logic              core_clk   = 1'b0;
  logic              resetn     = 1'b0;
  logic [2:0]        psel       = '0;
  logic              penable    = 1'b0;
  logic              pwrite     = 1'b0;
  logic [ADDR_W-1:0] paddr      = '0;
  logic [31:0]       pwdata     = '0;
  logic [31:0]       prdata [3];
  logic [2:0]        pready;
  logic [2:0]        pslverr;
  logic [2:0]        irq;
  logic [31:0]       rd;
  logic              er;
  logic              l2Run      = 1'b0;
  logic              prevSclk   = 1'b0;
  logic [1:0]        monCfg     = '0;
  logic [15:0]       monBits    = '0;
  int                monCnt     = 0;
  int                errCount   = 0;
  int                numChecks  = 0;

  sps_link_if link ();
  sps_link_if l2 ();
  sps_host_end i_sps_host_end (.core_clk, .resetn, .psel(psel[H]), .penable, .pwrite, .paddr,
    .pwdata, .prdata(prdata[H]), .pready(pready[H]), .pslverr(pslverr[H]), .irq(irq[H]),
    .link(link));
  sps_dev_end i_sps_dev_end (.core_clk, .resetn, .psel(psel[D]), .penable, .pwrite, .paddr,
    .pwdata, .prdata(prdata[D]), .pready(pready[D]), .pslverr(pslverr[D]), .irq(irq[D]),
    .link(link));
  // Second device end faces a bench driver that breaks the master's rules
  sps_dev_end i_sps_dev_end_2 (.core_clk, .resetn, .psel(psel[E]), .penable, .pwrite, .paddr,
    .pwdata, .prdata(prdata[E]), .pready(pready[E]), .pslverr(pslverr[E]), .irq(irq[E]),
    .link(l2));
  sps_link_sva i_sps_link_sva (.core_clk, .resetn, .sclk(link.sclk), .ssN(link.ssN),
    .mosi(link.mosi), .miso(link.miso), .misoOe(link.misoOe));

  always #25 core_clk = ~core_clk;
  // Free-running 400 ns link clock, moved only on core_clk edges
  always begin
    repeat (4) @(posedge core_clk);
    if (l2Run) l2.sclk <= ~l2.sclk;
  end
  initial begin
    l2.sclk = 1'b0;
    l2.ssN  = 1'b1;
    l2.mosi = 1'b0;
  end

  // Wire monitor: mosi taken on the sampling edge of the configured mode
  always @(posedge core_clk) begin
    prevSclk <= link.sclk;
    if (!link.ssN && link.sclk != prevSclk && (link.sclk ^ monCfg[0] ^ monCfg[1])) begin
      monBits <= {monBits[14:0], link.mosi};
      monCnt  <= monCnt + 1;
    end
  end

  task automatic tallyAndFinish();
    if (errCount == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      errCount++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    numChecks++;
    if (g !== e) begin
      errCount++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask

  // Waits as long as the slave needs; only the watchdog ends a hang
  task automatic apb(input int s, input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel[s] <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready[s] !== 1'b1);
    rd = prdata[s];
    er = pslverr[s];
    psel[s] <= 1'b0;
    penable <= 1'b0;
    // One wait state: pready seen at the second edge of the access phase
    chk("wait states", 32'h2, n);
  endtask

  task automatic rdchk(input int s, input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(s, 1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Host frame, then poll until done; the poll read clears done
  task automatic send(input logic [31:0] v);
    int n;
    apb(H, 1'b1, OFS_TX, v);
    n = 0;
    do begin
      apb(H, 1'b0, OFS_STAT, 32'h0);
      n++;
    end while (rd[ST_DONE] !== 1'b1 && n < 200);
    chk("host done", 32'h2, rd & 32'h3);
  endtask

  initial begin
    logic [31:0] m;
    int          n;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      m = (32'h1 << (ROW_CTL[i][7:4] + 1)) - 32'h1;
      monCfg = ROW_CTL[i][1:0];
      monCnt = 0;
      apb(H, 1'b1, OFS_CTRL, ROW_CTL[i]);
      apb(D, 1'b1, OFS_CTRL, ROW_CTL[i]);
      apb(D, 1'b1, OFS_TX, ROW_DTX[i]);
      rdchk(D, OFS_STAT, 32'h0, "dev fill low");
      send(ROW_HTX[i]);
      chk("mosi bits", ROW_HTX[i] & m, {16'h0, monBits} & m);
      chk("bit count", 32'(ROW_CTL[i][7:4]) + 32'h1, monCnt);
      chk1("sclk idle", ROW_CTL[i][0], link.sclk);
      chk1("dev irq masked", 1'b0, irq[D]);
      rdchk(H, OFS_RX, ROW_DTX[i] & m, "host rx");
      rdchk(D, OFS_STAT, 32'h7, "dev stat");
      rdchk(D, OFS_RX, ROW_HTX[i] & m, "dev rx");
      rdchk(D, OFS_STAT, 32'h1, "dev stat clr");
    end
    // Reset in mid-run returns every register to its reset value
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    chk1("miso idle", 1'b1, link.misoLine);
    rdchk(H, OFS_CTRL, 32'(CTRL_RST), "host ctrl");
    rdchk(D, OFS_CTRL, 32'(CTRL_RST), "dev ctrl");
    rdchk(D, OFS_MASK, 32'h0, "dev mask");
    rdchk(H, OFS_STAT, 32'h0, "host stat");
    rdchk(D, OFS_STAT, 32'h1, "dev stat rst");
    chk1("ok err", 1'b0, er);
    apb(D, 1'b1, OFS_CTRL, 32'hFFFFFFFF);
    rdchk(D, OFS_CTRL, 32'(CTRL_WMASK), "ctrl wmask");
    apb(D, 1'b1, OFS_CTRL, 32'(CTRL_RST));
    rdchk(D, 8'h14, 32'h0, "unmapped rd");
    chk1("unmapped err", 1'b1, er);
    apb(H, 1'b1, 8'h20, 32'h5);
    chk1("unmapped werr", 1'b1, er);
    // Full queue drops the second push; busy host drops the second frame
    apb(D, 1'b1, OFS_TX, 32'h11);
    apb(D, 1'b1, OFS_TX, 32'h22);
    apb(H, 1'b1, OFS_TX, 32'h81);
    send(32'h42);
    rdchk(H, OFS_RX, 32'h11, "host rx full");
    rdchk(D, OFS_RX, 32'h81, "dev rx busy");
    rdchk(D, OFS_STAT, 32'h3, "dev one frame");
    // Frame after the queue drained: dummy ones and underflow
    apb(H, 1'b1, OFS_MASK, 32'h2);
    apb(D, 1'b1, OFS_MASK, 32'h8);
    apb(H, 1'b1, OFS_TX, 32'h3C);
    rdchk(H, OFS_STAT, 32'h1, "host busy");
    n = 0;
    while (irq[H] !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    chk1("host irq", 1'b1, irq[H]);
    chk1("dev irq uf", 1'b1, irq[D]);
    rdchk(H, OFS_STAT, 32'h2, "host stat done");
    rdchk(D, OFS_STAT, 32'hF, "dev stat uf");
    repeat (2) @(posedge core_clk);
    chk(" irq cleared", 32'h0, {29'h0, irq});
    rdchk(D, OFS_MASK, 32'h8, "dev mask rd");
    rdchk(H, OFS_RX, 32'hFF, "host dummy");
    rdchk(D, OFS_RX, 32'h3C, "dev rx uf");
    // Clock and data while deselected, then a frame cut short
    l2Run <= 1'b1;
    repeat (40) @(posedge core_clk) l2.mosi <= ~l2.mosi;
    chk1("desel oe", 1'b0, l2.misoOe);
    chk1("desel pullup", 1'b1, l2.misoLine);
    rdchk(E, OFS_STAT, 32'h1, "desel stat");
    l2.ssN <= 1'b0;
    repeat (12) @(posedge core_clk);
    chk1("sel oe", 1'b1, l2.misoOe);
    l2.ssN <= 1'b1;
    repeat (8) @(posedge core_clk);
    l2Run <= 1'b0;
    chk1("abort oe", 1'b0, l2.misoOe);
    rdchk(E, OFS_STAT, 32'h9, "abort stat");
    tallyAndFinish();
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    chk1("watchdog", 1'b1, 1'b0);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
